// ==== design/synth_config_register_bank.sv ====
// Operation
// - select code 000 loads the integer and fraction register
// - select code 001 loads the prescaler, phase and modulus register
// - select code 010 loads the reference and loop control register
// - select code 101 loads pulse width, charge cancel and lock pin mode
// - bit 27 picks prescaler 4/5 or 8/9; host uses 8/9 above 3 GHz
// - bits 14..3 of register 1 hold the fraction modulus
// - noise mode bits 30..29; low-spur turns dither on, low-noise off
// - bits 28..26 drive the output multiplexer select
// - doubler off uses falling reference edge; on uses both edges
// - half divider adds a toggle stage after the reference counter
// - bits 23..14 set the reference divide ratio, 1 to 1023
// - bit 13 makes the output divider field wait for register 0
// - shadowed fields become active on the next register 0 write
// - output divider select sits in bits 22..20 of register 4
// - bits 11..9 select the charge pump current
// - lock counts 40 cycles when count bit is 0, 5 when 1
// - lock window is 10 ns when window bit is 0, 6 ns when 1
// - lock rises only after the selected run of in-window cycles
`include "synth_cfg_map.svh"
`default_nettype none
module synth_config_register_bank #(
  parameter int RDIV_W = 10,
  parameter int ERR_W  = 8
) (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       wrStrobe,
  input  wire logic [`WORD_W-1:0]         wrWord,
  input  wire logic                       refRise,
  input  wire logic                       refFall,
  input  wire logic [ERR_W-1:0]           phaseErrNs,
  output var  logic [15:0]                integerWord,
  output var  logic [11:0]                fraction_numerator,
  output var  logic                       prescaler_select,
  output var  logic [11:0]                phaseWord,
  output var  logic [11:0]                fraction_modulus,
  output var  synth_cfg_pkg::noise_mode_t noiseMode,
  output var  logic                       ditherEnable,
  output var  logic [2:0]                 output_mux_select,
  output var  logic                       refDoublerEnable,
  output var  logic                       reference_half_divider,
  output var  logic [RDIV_W-1:0]          refDivideRatio,
  output var  logic                       shadowed_bits,
  output var  logic [2:0]                 chargePumpCurrent,
  output var  logic                       lock_cycle_count_select,
  output var  logic                       lock_window_select,
  output var  logic [2:0]                 outDividerSelect,
  output var  logic [1:0]                 antibacklash_width,
  output var  logic                       charge_cancel_enable,
  output var  logic [1:0]                 lockPinMode,
  output var  logic                       pfdRefTick,
  output var  logic                       pfdRefLevel,
  output var  logic                       digitalLock
);
  import synth_cfg_pkg::*;

  // ************************************************************
  // write decode
  // ************************************************************
  logic [2:0]              register_select_code;
  logic [5:0]              wrHit;
  logic                    wrIntFrac;
  logic                    wrPreMod;
  logic                    wrRefLoop;
  logic                    wrOutDiv;
  logic                    wrPwLock;

  // ************************************************************
  // immediate fields
  // ************************************************************
  logic [15:0]             intWord_ff;
  logic [11:0]             fracNum_ff;
  logic                    presc_ff;
  noise_mode_t             noise_ff;
  logic                    dither_ff;
  logic [2:0]              mux_ff;
  logic                    shadowEn_ff;
  logic [2:0]              cp_ff;
  logic                    lcnt_ff;
  logic                    lwin_ff;
  logic [1:0]              abp_ff;
  logic                    cc_ff;
  logic [1:0]              ldPin_ff;

  // ************************************************************
  // shadow stage and active copies
  // ************************************************************
  logic [11:0]             phaseSh_ff;
  logic [11:0]             modSh_ff;
  logic                    dblSh_ff;
  logic                    halfSh_ff;
  logic [RDIV_W-1:0]       rdivSh_ff;
  logic [2:0]              odivSh_ff;
  logic [11:0]             phase_ff;
  logic [11:0]             mod_ff;
  logic                    dbl_ff;
  logic                    half_ff;
  logic [RDIV_W-1:0]       rdiv_ff;
  logic [2:0]              odiv_ff;
  logic [2:0]              nxt_odiv;

  // ************************************************************
  // reference path
  // ************************************************************
  logic [RDIV_W-1:0]       rCnt_ff;
  logic [RDIV_W-1:0]       nxt_rCnt;
  logic [RDIV_W-1:0]       ratioLast;
  logic                    activeEdge;
  logic                    rTick;
  logic                    toggle_ff;
  logic                    nxt_toggle;
  logic                    pfdTick;
  logic                    pfdTick_ff;
  logic                    pfdLevel_ff;
  logic                    nxt_pfdLevel;
  logic                    lockRaw;
  logic                    lock_ff;

  // legal ratios 1..1023; zero acts as 1
  function automatic logic [RDIV_W-1:0] lastCount(input logic [RDIV_W-1:0] ratio);
    lastCount = (ratio == '0) ? '0 : ratio - 1'b1;
  endfunction

  // ************************************************************
  // select code decode, one hit line per register
  // ************************************************************
  assign register_select_code = wrWord[`SEL_MSB:`SEL_LSB];

  genvar k;
  generate
    for (k = 0; k < 6; k++)
    begin : g_hit
      assign wrHit[k] = wrStrobe && (register_select_code == 3'(k));
    end
  endgenerate

  assign wrIntFrac = wrHit[SEL_INT_FRACTION_NUMERATOR];
  assign wrPreMod  = wrHit[SEL_PRE_MOD];
  assign wrRefLoop = wrHit[SEL_REF_LOOP];
  assign wrOutDiv  = wrHit[SEL_OUTDIV];
  assign wrPwLock  = wrHit[SEL_PW_LOCK];

  // ************************************************************
  // integer and fraction register, always immediate
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      intWord_ff <= '0;
      fracNum_ff <= '0;
    end
    else if (wrIntFrac)
    begin
      intWord_ff <= wrWord[`INT_MSB:`INT_LSB];
      fracNum_ff <= wrWord[`FRACTION_NUMERATOR_MSB:`FRACTION_NUMERATOR_LSB];
    end
  end

  // ************************************************************
  // prescaler immediate; phase and modulus into the shadow stage
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      presc_ff   <= 1'b0;
      phaseSh_ff <= `RST_PHASE;
      modSh_ff   <= '0;
    end
    else if (wrPreMod)
    begin
      presc_ff   <= wrWord[`PRESC_BIT];
      phaseSh_ff <= wrWord[`PHASE_MSB:`PHASE_LSB];
      modSh_ff   <= wrWord[`MOD_MSB:`MOD_LSB];
    end
  end

  // ************************************************************
  // loop control fields that act at once
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      noise_ff    <= NOISE_LOW_NOISE;
      dither_ff   <= 1'b0;
      mux_ff      <= '0;
      shadowEn_ff <= 1'b0;
      cp_ff       <= '0;
      lcnt_ff     <= 1'b0;
      lwin_ff     <= 1'b0;
    end
    else if (wrRefLoop)
    begin
      noise_ff    <= noise_mode_t'(wrWord[`NOISE_MSB:`NOISE_LSB]);
      dither_ff   <= wrWord[`NOISE_MSB:`NOISE_LSB] == NOISE_LOW_SPUR;
      mux_ff      <= wrWord[`MUX_MSB:`MUX_LSB];
      shadowEn_ff <= wrWord[`SHADOW_EN_BIT];
      cp_ff       <= wrWord[`CP_MSB:`CP_LSB];
      lcnt_ff     <= wrWord[`LCNT_BIT];
      lwin_ff     <= wrWord[`LWIN_BIT];
    end
  end

  // ************************************************************
  // reference fields into the shadow stage
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dblSh_ff  <= 1'b0;
      halfSh_ff <= 1'b0;
      rdivSh_ff <= `RST_RDIV;
    end
    else if (wrRefLoop)
    begin
      dblSh_ff  <= wrWord[`DOUBLER_BIT];
      halfSh_ff <= wrWord[`HALFDIV_BIT];
      rdivSh_ff <= wrWord[`RDIV_MSB:`RDIV_LSB];
    end
  end

  // ************************************************************
  // output divider select, shadow copy always follows a write
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      odivSh_ff <= '0;
    else if (wrOutDiv)
      odivSh_ff <= wrWord[`ODIV_MSB:`ODIV_LSB];
  end

  // direct unless shadowed, else wait for register 0
  assign nxt_odiv = (wrOutDiv && !shadowEn_ff) ? wrWord[`ODIV_MSB:`ODIV_LSB] :
                    (wrIntFrac && shadowEn_ff) ? odivSh_ff :
                    odiv_ff;

  // ************************************************************
  // register 0 write moves the shadow stage to the active copies
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_ff <= `RST_PHASE;
      mod_ff   <= '0;
      dbl_ff   <= 1'b0;
      half_ff  <= 1'b0;
      rdiv_ff  <= `RST_RDIV;
      odiv_ff  <= '0;
    end
    else
    begin
      odiv_ff <= nxt_odiv;
      if (wrIntFrac)
      begin
        phase_ff <= phaseSh_ff;
        mod_ff   <= modSh_ff;
        dbl_ff   <= dblSh_ff;
        half_ff  <= halfSh_ff;
        rdiv_ff  <= rdivSh_ff;
      end
    end
  end

  // ************************************************************
  // pulse width and lock pin register, immediate
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      abp_ff   <= '0;
      cc_ff    <= 1'b0;
      ldPin_ff <= '0;
    end
    else if (wrPwLock)
    begin
      abp_ff   <= wrWord[`ABP_MSB:`ABP_LSB];
      cc_ff    <= wrWord[`CC_BIT];
      ldPin_ff <= wrWord[`LDPIN_MSB:`LDPIN_LSB];
    end
  end

  // ************************************************************
  // reference counter and optional toggle stage
  // ************************************************************
  assign activeEdge = dbl_ff ? (refRise || refFall) : refFall;
  assign ratioLast  = lastCount(rdiv_ff);
  assign rTick      = activeEdge && (rCnt_ff >= ratioLast);

  // counter restarts whenever new settings go active
  assign nxt_rCnt = wrIntFrac ? '0 :
                    rTick ? '0 :
                    activeEdge ? rCnt_ff + 1'b1 :
                    rCnt_ff;

  // toggle stage halves the rate, even duty
  assign nxt_toggle   = wrIntFrac ? 1'b0 : (rTick ? !toggle_ff : toggle_ff);
  assign pfdTick      = half_ff ? (rTick && toggle_ff) : rTick;
  assign nxt_pfdLevel = half_ff ? nxt_toggle : rTick;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rCnt_ff     <= '0;
      toggle_ff   <= 1'b0;
      pfdTick_ff  <= 1'b0;
      pfdLevel_ff <= 1'b0;
    end
    else
    begin
      rCnt_ff     <= nxt_rCnt;
      toggle_ff   <= nxt_toggle;
      pfdTick_ff  <= pfdTick;
      pfdLevel_ff <= nxt_pfdLevel;
    end
  end

  // ************************************************************
  // digital lock detector on the comparison cycles
  // ************************************************************
  lock_detect_counter #(
    .CNT_W (6),
    .ERR_W (ERR_W)
  ) u_lock (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pfdTick      (pfdTick),
    .phaseErrNs   (phaseErrNs),
    .countSelect  (lcnt_ff),
    .windowSelect (lwin_ff),
    .clearLock    (wrIntFrac),
    .locked       (lockRaw)
  );

  // registered so the output comes from a flop
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      lock_ff <= 1'b0;
    else
      lock_ff <= lockRaw;
  end

  // ************************************************************
  // outputs, each a flip-flop
  // ************************************************************
  assign integerWord             = intWord_ff;
  assign fraction_numerator      = fracNum_ff;
  assign prescaler_select        = presc_ff;
  assign phaseWord               = phase_ff;
  assign fraction_modulus        = mod_ff;
  assign noiseMode               = noise_ff;
  assign ditherEnable            = dither_ff;
  assign output_mux_select       = mux_ff;
  assign refDoublerEnable        = dbl_ff;
  assign reference_half_divider  = half_ff;
  assign refDivideRatio          = rdiv_ff;
  assign shadowed_bits           = shadowEn_ff;
  assign chargePumpCurrent       = cp_ff;
  assign lock_cycle_count_select = lcnt_ff;
  assign lock_window_select      = lwin_ff;
  assign outDividerSelect        = odiv_ff;
  assign antibacklash_width      = abp_ff;
  assign charge_cancel_enable    = cc_ff;
  assign lockPinMode             = ldPin_ff;
  assign pfdRefTick              = pfdTick_ff;
  assign pfdRefLevel             = pfdLevel_ff;
  assign digitalLock             = lock_ff;
endmodule // synth_config_register_bank
`default_nettype wire

// ==== pkg/synth_cfg_map.svh ====
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// ************************************************************
// word layout common to all registers
// ************************************************************
`define WORD_W        32
`define SEL_MSB       2
`define SEL_LSB       0

// ************************************************************
// integer and fraction word fields
// ************************************************************
`define INT_MSB       30
`define INT_LSB       15
`define FRACTION_NUMERATOR_MSB      14
`define FRACTION_NUMERATOR_LSB      3

// ************************************************************
// prescaler, phase and modulus fields
// ************************************************************
`define PRESC_BIT     27
`define PHASE_MSB     26
`define PHASE_LSB     15
`define MOD_MSB       14
`define MOD_LSB       3

// ************************************************************
// reference and loop control fields
// ************************************************************
`define NOISE_MSB     30
`define NOISE_LSB     29
`define MUX_MSB       28
`define MUX_LSB       26
`define DOUBLER_BIT   25
`define HALFDIV_BIT   24
`define RDIV_MSB      23
`define RDIV_LSB      14
`define SHADOW_EN_BIT 13
`define CP_MSB        11
`define CP_LSB        9
`define LCNT_BIT      8
`define LWIN_BIT      7

// ************************************************************
// output divider and pulse width / lock pin fields
// ************************************************************
`define ODIV_MSB      22
`define ODIV_LSB      20
`define ABP_MSB       31
`define ABP_LSB       30
`define CC_BIT        29
`define LDPIN_MSB     23
`define LDPIN_LSB     22

// ************************************************************
// reset values and lock detector figures
// ************************************************************
`define RST_RDIV      10'h001
`define RST_PHASE     12'h001
`define LOCK_CNT_LONG 6'h28
`define LOCK_CNT_SHRT 6'h05
`define LOCK_WIN_WIDE 8'h0A
`define LOCK_WIN_NARR 8'h06

`endif

// ==== pkg/synth_cfg_pkg.sv ====
`default_nettype none
// ************************************************************
// types shared by the register bank and the lock detector
// ************************************************************
package synth_cfg_pkg;
  typedef enum logic [2:0] {
    SEL_INT_FRACTION_NUMERATOR = 3'h0,
    SEL_PRE_MOD  = 3'h1,
    SEL_REF_LOOP = 3'h2,
    SEL_CLKDIV   = 3'h3,
    SEL_OUTDIV   = 3'h4,
    SEL_PW_LOCK  = 3'h5
  } reg_sel_t;
  typedef enum logic [1:0] {
    NOISE_LOW_NOISE = 2'h0,
    NOISE_LOW_SPUR  = 2'h3
  } noise_mode_t;
  typedef enum logic {
    LOCK_HUNT   = 1'b0,
    LOCK_LOCKED = 1'b1
  } lock_state_t;
endpackage
`default_nettype wire

// ==== design/lock_detect_counter.sv ====
`include "synth_cfg_map.svh"
`default_nettype none
module lock_detect_counter #(
  parameter int CNT_W = 6,
  parameter int ERR_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             pfdTick,
  input  wire logic [ERR_W-1:0] phaseErrNs,
  input  wire logic             countSelect,
  input  wire logic             windowSelect,
  input  wire logic             clearLock,
  output var  logic             locked
);
  import synth_cfg_pkg::*;

  lock_state_t            state_ff;
  lock_state_t            nxt_state;
  logic       [CNT_W-1:0] good_ff;
  logic       [CNT_W-1:0] nxt_good;
  logic       [CNT_W-1:0] target;
  logic       [ERR_W-1:0] window;
  logic                   inWindow;

  // ************************************************************
  // window and count selection
  // ************************************************************
  assign target   = countSelect ? `LOCK_CNT_SHRT : `LOCK_CNT_LONG;
  assign window   = windowSelect ? `LOCK_WIN_NARR : `LOCK_WIN_WIDE;
  assign inWindow = phaseErrNs < window;

  // consecutive good cycles; one bad cycle starts over
  assign nxt_good = clearLock ? '0 :
                    !pfdTick ? good_ff :
                    !inWindow ? '0 :
                    (good_ff == target) ? good_ff :
                    good_ff + 1'b1;

  // lock once the chosen run of good cycles is done
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      LOCK_HUNT:
      begin
        if (nxt_good == target && !clearLock)
          nxt_state = LOCK_LOCKED;
      end
      LOCK_LOCKED:
      begin
        if (clearLock || (pfdTick && !inWindow))
          nxt_state = LOCK_HUNT;
      end
    endcase
  end

  // ************************************************************
  // state registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= LOCK_HUNT;
      good_ff  <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      good_ff  <= nxt_good;
    end
  end

  assign locked = (state_ff == LOCK_LOCKED);
endmodule // lock_detect_counter
`default_nettype wire

// ==== test/host_model.sv ====
`default_nettype none
// ************************************************************
// host side: word writer and reference edge source
// ************************************************************
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        refOn,
  output var  logic        wrStrobe,
  output var  logic [31:0] wrWord,
  output var  logic        refRise,
  output var  logic        refFall
);
  logic [1:0] phase_ff = 2'h0;
  initial
  begin
    wrStrobe = 1'b0;
    wrWord   = 32'h0;
    refRise  = 1'b0;
    refFall  = 1'b0;
  end
  // one whole word per write
  task automatic send(input logic [31:0] w);
    @(negedge clk_sys);
    wrStrobe = 1'b1;
    wrWord   = w;
    @(negedge clk_sys);
    wrStrobe = 1'b0;
    wrWord   = ~w; // stale data inverted
  endtask
  // fall every fourth cycle, rise halfway between
  always @(negedge clk_sys)
  begin
    phase_ff <= phase_ff + 2'h1;
    refFall  <= refOn && phase_ff == 2'h0;
    refRise  <= refOn && phase_ff == 2'h2;
  end
endmodule // host_model
`default_nettype wire

// ==== test/synth_config_register_bank_asserts.sv ====
`include "synth_cfg_map.svh"
`default_nettype none
module synth_config_register_bank_asserts #(
  parameter int RDIV_W = 10
) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               wrStrobe,
  input wire logic [`WORD_W-1:0] wrWord,
  input wire logic [15:0]        integerWord,
  input wire logic               prescaler_select,
  input wire logic [11:0]        phaseWord,
  input wire logic [11:0]        fraction_modulus,
  input wire logic               ditherEnable,
  input wire logic [2:0]         output_mux_select,
  input wire logic [RDIV_W-1:0]  refDivideRatio,
  input wire logic               shadowed_bits,
  input wire logic [2:0]         outDividerSelect,
  input wire logic               charge_cancel_enable,
  input wire logic [1:0]         lockPinMode,
  input wire logic               digitalLock
);
  import synth_cfg_pkg::*;
  // ************************************************************
  // write decode and helpers
  // ************************************************************
  wire logic [2:0] code = wrWord[`SEL_MSB:`SEL_LSB];
  wire logic wr0 = wrStrobe && code == 3'h0;
  wire logic wr1 = wrStrobe && code == 3'h1;
  wire logic wr2 = wrStrobe && code == 3'h2;
  wire logic wr4 = wrStrobe && code == 3'h4;
  wire logic wr5 = wrStrobe && code == 3'h5;
  logic [31:0] last_ff;
  logic [11:0] pendMod_ff;
  // last word; modulus pending a register 0 write
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pendMod_ff <= 12'h000;
    else if (wr1)
      pendMod_ff <= wrWord[`MOD_MSB:`MOD_LSB];
  end
  always_ff @(posedge clk_sys)
    last_ff <= wrWord;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_int; wr0 |=> integerWord == last_ff[30:15]; endproperty
  a_int: assert property (p_int) else $error("integer word not loaded");
  property p_presc; wr1 |=> prescaler_select == last_ff[27]; endproperty
  a_presc: assert property (p_presc) else $error("prescaler not loaded");
  property p_mux; wr2 |=> output_mux_select == last_ff[28:26]; endproperty
  a_mux: assert property (p_mux) else $error("mux select not loaded");
  property p_dither; wr2 |=> ditherEnable == (last_ff[30:29] == 2'h3); endproperty
  a_dither: assert property (p_dither) else $error("dither wrong");
  property p_reg5;
    wr5 |=> {charge_cancel_enable, lockPinMode} == {last_ff[29], last_ff[23:22]};
  endproperty
  a_reg5: assert property (p_reg5) else $error("lock pin fields wrong");
  property p_hold;
    !$past(wr0) |-> $stable(refDivideRatio) && $stable(fraction_modulus) && $stable(phaseWord);
  endproperty
  a_hold: assert property (p_hold) else $error("shadowed field moved");
  property p_mod; wr0 |=> fraction_modulus == pendMod_ff; endproperty
  a_mod: assert property (p_mod) else $error("modulus not promoted");
  property p_odiv; wr4 && !shadowed_bits |=> outDividerSelect == last_ff[22:20]; endproperty
  a_odiv: assert property (p_odiv) else $error("divider select wrong");
  property p_clear; wr0 |-> ##2 !digitalLock; endproperty
  a_clear: assert property (p_clear) else $error("lock kept after write");
  c_lock: cover property ($rose(digitalLock));
  c_shadow: cover property (wr4 && shadowed_bits);
  c_ignored: cover property (wrStrobe && code == 3'h3);
endmodule // synth_config_register_bank_asserts
bind synth_config_register_bank synth_config_register_bank_asserts #(.RDIV_W(RDIV_W)) chk_i (
  .clk_sys, .resetn, .wrStrobe, .wrWord, .integerWord, .prescaler_select, .phaseWord,
  .fraction_modulus, .ditherEnable, .output_mux_select, .refDivideRatio, .shadowed_bits,
  .outDividerSelect, .charge_cancel_enable, .lockPinMode, .digitalLock);
`default_nettype wire

// ==== test/synth_config_register_bank_test.sv ====
`default_nettype none
module synth_config_register_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_cfg_pkg::*;
  // ************************************************************
  // bench signals, rows and tasks
  // ************************************************************
  typedef struct packed { logic [31:0] word; logic [10:0] exp; } row_t;
  row_t        rows [4] = '{'{32'h14000482, 11'h0A9}, '{32'h28000F02, 11'h25E},
                            '{32'h5C000182, 11'h4E3}, '{32'h60000A02, 11'h714}};
  logic [31:0] badCodes [3] = '{32'hFFFFFFFB, 32'hFFFFFFFE, 32'hFFFFFFFF};
  logic        clk_sys = 1'b0, resetn = 1'b0, refOn = 1'b0;
  logic [7:0]  phaseErrNs = 8'h03;
  logic [31:0] wrWord;
  logic [15:0] integerWord;
  logic [11:0] fraction_numerator, phaseWord, fraction_modulus;
  logic [9:0]  refDivideRatio;
  logic [2:0]  output_mux_select, chargePumpCurrent, outDividerSelect;
  logic [1:0]  antibacklash_width, lockPinMode;
  logic        wrStrobe, refRise, refFall, prescaler_select, ditherEnable, refDoublerEnable;
  logic        shadowed_bits, lock_cycle_count_select, lock_window_select, reference_half_divider;
  logic        charge_cancel_enable, pfdRefTick, digitalLock, pfdRefLevel;
  noise_mode_t noiseMode;
  int          nErrors = 0, testsRun = 0, nTicks = 0;
  wire [10:0]  reg2Fields = {noiseMode, ditherEnable, output_mux_select, chargePumpCurrent,
                             lock_cycle_count_select, lock_window_select};
  host_model host (.clk_sys, .refOn, .wrStrobe, .wrWord, .refRise, .refFall);
  synth_config_register_bank dut (.clk_sys, .resetn, .wrStrobe, .wrWord, .refRise, .refFall,
    .phaseErrNs, .integerWord, .fraction_numerator, .prescaler_select, .phaseWord,
    .fraction_modulus, .noiseMode, .ditherEnable, .output_mux_select, .refDoublerEnable,
    .reference_half_divider, .refDivideRatio, .shadowed_bits, .chargePumpCurrent,
    .lock_cycle_count_select, .lock_window_select, .outDividerSelect, .antibacklash_width,
    .charge_cancel_enable, .lockPinMode, .pfdRefTick, .pfdRefLevel, .digitalLock);
  always #50 clk_sys = ~clk_sys;
  // half divider on: level sits low as each tick leaves
  always @(negedge clk_sys)
    if (pfdRefTick === 1'b1)
    begin
      nTicks <= nTicks + 1;
      chk("pfdRefLevel", 16'h0, 16'(pfdRefLevel));
    end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e)
    begin
      nErrors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // bounded wait for a lock level
  task automatic waitLock(input logic want);
    for (int i = 0; i < 400 && digitalLock !== want; i++)
      @(negedge clk_sys);
  endtask
  task automatic endOfTest();
    $display("errors %0d checks %0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    endOfTest();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    foreach (rows[k])
    begin
      host.send(rows[k].word);
      chk("reg2 fields", 16'(rows[k].exp), 16'(reg2Fields));
      chk("refDivideRatio", 16'h1, 16'(refDivideRatio));
    end
    host.send(32'h080080C9);
    chk("prescaler_select", 16'h1, 16'(prescaler_select));
    chk("fraction_modulus", 16'h0, 16'(fraction_modulus));
    host.send(32'h0300A182);
    chk("refDivideRatio", 16'h1, 16'(refDivideRatio));
    host.send(32'h00300004);
    chk("outDividerSelect", 16'h0, 16'(outDividerSelect));
    host.send(32'h003C0008);
    chk("integerWord", 16'h0078, integerWord);
    chk("fraction_numerator", 16'h1, 16'(fraction_numerator));
    chk("fraction_modulus", 16'h0019, 16'(fraction_modulus));
    chk("phaseWord", 16'h1, 16'(phaseWord));
    chk("refDivideRatio", 16'h2, 16'(refDivideRatio));
    chk("refDoublerEnable", 16'h1, 16'(refDoublerEnable));
    chk("reference_half_divider", 16'h1, 16'(reference_half_divider));
    chk("outDividerSelect", 16'h3, 16'(outDividerSelect));
    nTicks = 0;
    refOn = 1'b1;
    waitLock(1'b1);
    chk("ticks at lock", 16'h5, 16'(nTicks));
    phaseErrNs = 8'h06;
    waitLock(1'b0);
    chk("digitalLock", 16'h0, 16'(digitalLock));
    host.send(32'hB0C00005);
    chk("reg5", 16'h17, 16'({antibacklash_width, charge_cancel_enable, lockPinMode}));
    foreach (badCodes[k])
    begin
      host.send(badCodes[k]);
      chk("integerWord", 16'h0078, integerWord);
      chk("lockPinMode", 16'h3, 16'(lockPinMode));
    end
    host.send(32'h00008182);
    host.send(32'h00600004);
    chk("outDividerSelect", 16'h6, 16'(outDividerSelect));
    resetn = 1'b0;
    @(negedge clk_sys);
    chk("phaseWord", 16'h1, 16'(phaseWord));
    chk("integerWord", 16'h0, integerWord);
    resetn = 1'b1;
    endOfTest();
  end
endmodule // synth_config_register_bank_test
`default_nettype wire
